// ### inc/pimd_defines.svh
`ifndef PIMD_DEFINES_SVH
`define PIMD_DEFINES_SVH

// Register byte offsets
`define PIMD_CTRL_OFF      12'h000
`define PIMD_STAT_OFF      12'h004
`define PIMD_PRIO_OFF      12'h008
`define PIMD_OUT_ADDR_OFF  12'h00C
`define PIMD_OUT_DATA_OFF  12'h010
`define PIMD_PEND_OFF      12'h014
`define PIMD_PRIO_BASE_OFF 12'h080
`define PIMD_ENT_LO_OFF    12'h100
`define PIMD_ENT_HI_OFF    12'h104
// Control fields
`define PIMD_CTRL_REDIR_BIT 0
`define PIMD_CTRL_RESET     32'h0000_0001
// Address window and fields
`define PIMD_WIN_HI        12'hFEE
`define PIMD_HINT_BIT      3
`define PIMD_EID_LSB       4
`define PIMD_ID_LSB        12
// Data fields
`define PIMD_DM_LSB        8
`define PIMD_TRIG_BIT      15
`define PIMD_MASK_BIT      16
`define PIMD_DM_FIXED      3'h0
`define PIMD_VEC_MIN       8'h10
// Entry layout in the upper half
`define PIMD_HI_EID_LSB    16
`define PIMD_HI_ID_LSB     24
`define PIMD_HI_HINT_BIT   0
// Priority register fields
`define PIMD_PRIO_EN_BIT   7
`define PIMD_PRIO_RESET    8'h00
`endif

// ### inc/pimd_pkg.sv
package pimd_pkg;
    // Router sequencing
    typedef enum logic [1:0] {PIMD_IDLE, PIMD_SEND, PIMD_WAIT} pimd_state_t;
endpackage

// ### inc/pimd_sel_if.sv
`timescale 1ns/10ps
// Carries priority table to the selector and the chosen processor back
interface pimd_sel_if #(parameter int NPROC = 4);
    logic [NPROC*8-1:0] prio;
    logic [NPROC-1:0]   en;
    logic [$clog2(NPROC)-1:0] pick;
    logic               any;
    modport bridge (output prio, output en, input pick, input any);
    modport sel    (input prio, input en, output pick, output any);
endinterface

// ### hw/pimd_lowest_sel.sv
`timescale 1ns/10ps
`include "pimd_defines.svh"
// Finds the enabled processor with the lowest task priority
module pimd_lowest_sel #(
    parameter int NPROC = 4
) (
    pimd_sel_if.sel s
);
    // Linear scan; ties go to the lowest index so the choice is stable
    always_comb begin
        logic [7:0] best;
        best = 8'hFF;
        s.pick = '0;
        s.any = 1'b0;
        for (int i = 0; i < NPROC; i++) begin
            // Disabled processors never win
            if (s.en[i] && (!s.any || s.prio[i*8 +: 8] < best)) begin
                best = s.prio[i*8 +: 8];
                s.pick = i[$clog2(NPROC)-1:0];
                s.any = 1'b1;
            end
        end
    end
endmodule

// ### hw/pimd_top.sv
`timescale 1ns/10ps
`include "pimd_defines.svh"
// Interrupt router plus redirecting bridge, APB programmed.
// Entries: index e at ENT_LO + 8*e (lower half) and ENT_HI + 8*e.
module pimd_top #(
    parameter int NPIN  = 8,
    parameter int NPROC = 4
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NPIN-1:0]   irq_pin,
    input  wire logic [NPIN-1:0]   irq_level,
    input  wire logic              data_writes_idle,
    output logic                   msg_valid,
    input  wire logic              msg_ready,
    output logic [31:0]            msg_addr,
    output logic [31:0]            msg_data
);
    localparam int PW = $clog2(NPIN);
    localparam int QW = $clog2(NPROC);

    // Entry storage, lower and upper halves
    logic [31:0] ent_lo_q [NPIN];
    logic [31:0] ent_lo_d [NPIN];
    logic [31:0] ent_hi_q [NPIN];
    logic [31:0] ent_hi_d [NPIN];
    logic [NPIN-1:0] status_q, status_d;   // Delivery status bits
    logic [NPIN-1:0] pin_prev_q, pin_prev_d; // Previous pin sample for edges
    logic [31:0]     ctrl_q, ctrl_d;       // Bit 0 enables redirection
    logic [7:0]      prio_q [NPROC];       // Task priority trackers
    logic [7:0]      prio_d [NPROC];
    pimd_pkg::pimd_state_t st_q, st_d;
    logic [PW-1:0]   cur_q, cur_d;         // Pin being delivered
    logic [31:0]     addr_q, addr_d;
    logic [31:0]     data_q, data_d;
    logic            valid_q, valid_d;

    // Decoded APB strobes
    logic        wr_en;
    logic        rd_en;
    logic        ent_hit;
    logic [PW-1:0] ent_idx;
    logic        ent_hi_sel;
    logic        prio_hit;
    logic [QW-1:0] prio_idx;
    logic [31:0] rdata;
    logic        bad_addr;

    // Pin level combined with its trigger mode
    logic [NPIN-1:0] recog;
    logic            have;
    logic [PW-1:0]   first;

    pimd_sel_if #(.NPROC(NPROC)) sif ();
    pimd_lowest_sel #(.NPROC(NPROC)) u_sel (.s(sif.sel));

    // Zero wait state slave
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign ent_hit = (paddr >= `PIMD_ENT_LO_OFF) && (paddr < `PIMD_ENT_LO_OFF + 12'(8*NPIN));
    assign ent_idx = PW'((paddr - `PIMD_ENT_LO_OFF) >> 3);
    assign ent_hi_sel = paddr[2];
    assign prio_hit = (paddr >= `PIMD_PRIO_BASE_OFF)
                      && (paddr < `PIMD_PRIO_BASE_OFF + 12'(4*NPROC));
    assign prio_idx = QW'((paddr - `PIMD_PRIO_BASE_OFF) >> 2);

    // Priority table goes to the selector with its enable bits
    always_comb begin
        for (int i = 0; i < NPROC; i++) begin
            sif.prio[i*8 +: 8] = prio_q[i];
            sif.en[i] = prio_q[i][`PIMD_PRIO_EN_BIT];
        end
    end

    // Read mux and unmapped decode
    always_comb begin
        rdata = 32'h0000_0000;
        bad_addr = 1'b0;
        if (paddr[1:0] != 2'h0) begin
            bad_addr = 1'b1;
        end else if (ent_hit) begin
            rdata = ent_hi_sel ? ent_hi_q[ent_idx] : ent_lo_q[ent_idx];
        end else if (prio_hit) begin
            rdata = {24'h00_0000, prio_q[prio_idx]};
        end else begin
            unique case (paddr)
                `PIMD_CTRL_OFF:     rdata = ctrl_q;
                `PIMD_STAT_OFF:     rdata = 32'(status_q);
                `PIMD_OUT_ADDR_OFF: rdata = addr_q;
                `PIMD_OUT_DATA_OFF: rdata = data_q;
                `PIMD_PEND_OFF:     rdata = {31'h0000_0000, valid_q};
                default:            bad_addr = 1'b1;
            endcase
        end
    end

    // Read data registered; error flagged only in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata;
        end
    end
    assign pslverr = psel & penable & bad_addr;

    // Register writes
    always_comb begin
        ctrl_d = ctrl_q;
        for (int i = 0; i < NPIN; i++) begin
            ent_lo_d[i] = ent_lo_q[i];
            ent_hi_d[i] = ent_hi_q[i];
        end
        for (int i = 0; i < NPROC; i++) begin
            prio_d[i] = prio_q[i];
        end
        if (wr_en && !bad_addr) begin
            if (ent_hit && ent_hi_sel) begin
                ent_hi_d[ent_idx] = pwdata;
            end else if (ent_hit) begin
                ent_lo_d[ent_idx] = pwdata;
            end else if (prio_hit) begin
                prio_d[prio_idx] = pwdata[7:0];
            end else if (paddr == `PIMD_CTRL_OFF) begin
                ctrl_d = pwdata;
            end
        end
    end

    // Recognition: edges need a rise, levels need the pin high
    always_comb begin
        for (int i = 0; i < NPIN; i++) begin
            recog[i] = (irq_level[i] ? irq_pin[i] : irq_pin[i] & ~pin_prev_q[i])
                       & ~ent_lo_q[i][`PIMD_MASK_BIT];
        end
        have = 1'b0;
        first = '0;
        for (int i = NPIN - 1; i >= 0; i--) begin
            if (status_q[i]) begin
                have = 1'b1;
                first = PW'(i);
            end
        end
    end

    // Router and bridge sequencing
    always_comb begin
        logic [15:0] dest;
        logic        hint;
        dest = 16'h0000;
        hint = 1'b0;
        st_d = st_q;
        cur_d = cur_q;
        addr_d = addr_q;
        data_d = data_q;
        valid_d = valid_q;
        status_d = status_q;
        pin_prev_d = irq_pin;
        unique case (st_q)
            pimd_pkg::PIMD_IDLE: begin
                // Hold off until earlier data writes have drained
                if (have && data_writes_idle) begin
                    cur_d = first;
                    st_d = pimd_pkg::PIMD_SEND;
                end
            end
            pimd_pkg::PIMD_SEND: begin
                dest = {ent_hi_q[cur_q][`PIMD_HI_ID_LSB +: 8],
                        ent_hi_q[cur_q][`PIMD_HI_EID_LSB +: 8]};
                hint = ent_hi_q[cur_q][`PIMD_HI_HINT_BIT];
                // Lowest priority redirect only with a hint and an enabled tracker
                if (hint && ctrl_q[`PIMD_CTRL_REDIR_BIT] && sif.any) begin
                    dest[15:8] = 8'(sif.pick);
                end
                // Hint always cleared on the processor side
                addr_d = {`PIMD_WIN_HI, dest[15:8], dest[7:0], 1'b0, 3'h0};
                // Lower entry half, delivery mode forced to fixed
                data_d = ent_lo_q[cur_q];
                data_d[`PIMD_DM_LSB +: 3] = `PIMD_DM_FIXED;
                data_d[`PIMD_TRIG_BIT] = 1'b0;
                valid_d = 1'b1;
                st_d = pimd_pkg::PIMD_WAIT;
            end
            pimd_pkg::PIMD_WAIT: begin
                if (msg_ready) begin
                    valid_d = 1'b0;
                    status_d[cur_q] = 1'b0;
                    st_d = pimd_pkg::PIMD_IDLE;
                end
            end
            default: st_d = pimd_pkg::PIMD_IDLE;
        endcase
        // A new recognition wins over the clear of the same bit
        status_d = status_d | recog;
    end

    // State registers; reset drops every pending message
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= pimd_pkg::PIMD_IDLE;
            cur_q <= '0;
            addr_q <= 32'h0000_0000;
            data_q <= 32'h0000_0000;
            valid_q <= 1'b0;
            status_q <= '0;
            pin_prev_q <= '0;
            ctrl_q <= `PIMD_CTRL_RESET;
            for (int i = 0; i < NPIN; i++) begin
                ent_lo_q[i] <= 32'(1) << `PIMD_MASK_BIT;
                ent_hi_q[i] <= 32'h0000_0000;
            end
            for (int i = 0; i < NPROC; i++) begin
                prio_q[i] <= `PIMD_PRIO_RESET;
            end
        end else begin
            st_q <= st_d;
            cur_q <= cur_d;
            addr_q <= addr_d;
            data_q <= data_d;
            valid_q <= valid_d;
            status_q <= status_d;
            pin_prev_q <= pin_prev_d;
            ctrl_q <= ctrl_d;
            for (int i = 0; i < NPIN; i++) begin
                ent_lo_q[i] <= ent_lo_d[i];
                ent_hi_q[i] <= ent_hi_d[i];
            end
            for (int i = 0; i < NPROC; i++) begin
                prio_q[i] <= prio_d[i];
            end
        end
    end

    assign msg_valid = valid_q;
    assign msg_addr  = addr_q;
    assign msg_data  = data_q;
endmodule

// ### test/pimd_top_sva.sv
`timescale 1ns/10ps
// Watches the message port of the delivery block
module pimd_top_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        data_writes_idle,
    input wire logic        msg_valid,
    input wire logic        msg_ready,
    input wire logic [31:0] msg_addr,
    input wire logic [31:0] msg_data
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A stalled message must not change under the taker
    property p_hold;
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr) && $stable(msg_data);
    endproperty
    a_hold: assert property (p_hold) else $error("message changed while stalled");
    // Bridges spot interrupts by the leading address bits
    property p_window;
        msg_valid |-> msg_addr[31:20] == 12'hFEE;
    endproperty
    a_window: assert property (p_window) else $error("address outside window");
    // Hint never reaches the system bus
    property p_hint;
        msg_valid |-> !msg_addr[3] && msg_addr[2:0] == 3'h0;
    endproperty
    a_hint: assert property (p_hint) else $error("redirect hint still set");
    // Delivery mode is always fixed
    property p_mode;
        msg_valid |-> msg_data[10:8] == 3'h0;
    endproperty
    a_mode: assert property (p_mode) else $error("delivery mode not fixed");
    // Level pins still give edge messages
    property p_edge;
        msg_valid |-> !msg_data[15];
    endproperty
    a_edge: assert property (p_edge) else $error("trigger not edge");
    // No message overtakes data writes still in flight
    property p_order;
        $rose(msg_valid) |-> $past(data_writes_idle, 2);
    endproperty
    a_order: assert property (p_order) else $error("message before data settled");
    // Nothing is left pending across reset
    property p_reset;
        $rose(presetn) |-> !msg_valid;
    endproperty
    a_reset: assert property (p_reset) else $error("message pending after reset");
    // One message is one write: it ends at its handshake
    property p_single;
        msg_valid && msg_ready |=> !msg_valid;
    endproperty
    a_single: assert property (p_single) else $error("message repeated");
endmodule
bind pimd_top pimd_top_chk u_chk (.pclk(pclk), .presetn(presetn),
    .data_writes_idle(data_writes_idle), .msg_valid(msg_valid), .msg_ready(msg_ready),
    .msg_addr(msg_addr), .msg_data(msg_data));

// ### test/pimd_proc_model.sv
`timescale 1ns/10ps
// Processor side: takes each message after a chosen stall
module pimd_proc_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [3:0]  stall,
    input  wire logic        msg_valid,
    input  wire logic [31:0] msg_addr,
    input  wire logic [31:0] msg_data,
    output logic             msg_ready,
    output logic [31:0]      got_addr,
    output logic [31:0]      got_data,
    output logic [7:0]       got_cnt
);
    logic [3:0] wait_q; // Cycles already stalled
    // Slow answers make the sender hold its message
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_ready <= 1'b0;
            wait_q <= 4'h0;
            got_cnt <= 8'h00;
            got_addr <= 32'h0;
            got_data <= 32'h0;
        end else if (msg_valid && !msg_ready) begin
            if (wait_q == stall) msg_ready <= 1'b1;
            else wait_q <= wait_q + 4'h1;
        end else begin
            msg_ready <= 1'b0;
            wait_q <= 4'h0;
            // Taken at the handshake edge only; this processor issues no stores
            // or reads into the window, so no peer interrupt is ever malformed
            if (msg_valid) begin
                got_addr <= msg_addr;
                got_data <= msg_data;
                got_cnt <= got_cnt + 8'h01;
            end
        end
    end
endmodule

// ### test/tb_platform_interrupt_message_delivery.sv
`timescale 1ns/10ps
// Programs entries over APB, fires pins, checks messages
module tb_platform_interrupt_message_delivery;
    logic        pclk, presetn, psel, penable, pwrite, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, msg_addr, msg_data, got_addr, got_data;
    logic        pready, pslverr, data_writes_idle, msg_valid, msg_ready;
    logic [7:0]  irq_pin, irq_level, got_cnt, seen;
    logic [3:0]  stall;
    int          fails, compares;
    logic [7:0]  prio [4] = '{8'h85, 8'h01, 8'h82, 8'h82}; // Ties go to the lower index

    pimd_top #(.NPIN(8), .NPROC(4)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_pin(irq_pin),
        .irq_level(irq_level), .data_writes_idle(data_writes_idle),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_addr(msg_addr),
        .msg_data(msg_data));
    pimd_proc_model u_proc (.pclk(pclk), .presetn(presetn), .stall(stall),
        .msg_valid(msg_valid), .msg_addr(msg_addr), .msg_data(msg_data),
        .msg_ready(msg_ready), .got_addr(got_addr), .got_data(got_data), .got_cnt(got_cnt));

    // Verdict and end of run
    task end_of_test;
        if (fails == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer; an idle edge follows so strobes never double up
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Pin high for exactly one bus clock, the shortest legal pulse
    task pulse(input int p);
        seen = got_cnt;
        irq_pin[p] <= 1'b1;
        @(posedge pclk);
        irq_pin[p] <= 1'b0;
        @(posedge pclk);
    endtask
    task await(input logic [31:0] ea, input logic [31:0] ed);
        for (int i = 0; i < 100 && got_cnt === seen; i++) @(posedge pclk);
        chk("msg_addr", ea, got_addr);
        chk("msg_data", ed, got_data);
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // Hang guard, far beyond the fewer than one hundred cycles needed
    initial begin
        repeat (5000) @(posedge pclk);
        fails++;
        end_of_test;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, irq_pin} = '0;
        irq_level = 8'h01;
        data_writes_idle = 1'b1;
        stall = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h1, rd);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", 32'h0, rd);
        apb(1'b0, 12'hFFC, 32'h0);
        chk("pslverr", 32'h1, {31'h0, err});
        // Level pin, odd mode and trigger written; message held behind data
        apb(1'b1, 12'h100, 32'h0000_8531);
        apb(1'b1, 12'h104, 32'h1234_0000);
        data_writes_idle <= 1'b0;
        pulse(0);
        repeat (8) @(posedge pclk);
        chk("count", {24'h0, seen}, {24'h0, got_cnt});
        apb(1'b0, 12'h004, 32'h0);
        chk("status", 32'h1, rd);
        data_writes_idle <= 1'b1;
        await(32'hFEE1_2340, 32'h0000_0031);
        apb(1'b0, 12'h004, 32'h0);
        chk("status", 32'h0, rd);
        // Hinted entry goes to the lowest enabled priority, slow taker
        apb(1'b1, 12'h108, 32'h0000_0042);
        apb(1'b1, 12'h10C, 32'h7705_0001);
        for (int p = 0; p < 4; p++) apb(1'b1, 12'h080 + 12'(4 * p), {24'h0, prio[p]});
        stall <= 4'h5;
        pulse(1);
        await(32'hFEE0_2050, 32'h0000_0042);
        // Every tracker disabled: destination left alone
        for (int p = 0; p < 4; p++) apb(1'b1, 12'h080 + 12'(4 * p), 32'h0);
        pulse(1);
        await(32'hFEE7_7050, 32'h0000_0042);
        end_of_test;
    end
endmodule
